// File: muxed_host_command_port.sv
// multiplexed address/data host port with command and status registers
//
// Overview of operation
// [R1] address strobe fall latches bus and select
// [R2] address bits: index, execute, nibble, select
// [R3] selected when nibble is 2, select low
// [R4] unselected: bus floats, no register writes
// [R5] data access only while selected, strobe low
// [R6] index zero: command write, status read
// [R7] indices one-seven are argument registers
// [R8] indirect registers and memory reached through them
// [R9] command: four-bit type, four parameter bits
// [R10] direction one moves toward data registers
// [R11] increment and pointer select parameter bits
// [R12] move source/destination codes 01 and 10
// [R13] stop codes: 01 buffer end, 10 never
// [R14] busy set at start, cleared at completion
// [R15] row end flag when pointer x is 39
// [R16] alarm when row end and increment
// [R17] status bit 3 shows data one msb
// [R18] status bit 2 shows masked vertical sync
// [R19] mask set forces status bit 2 low
// [R20] status bits one and zero read zero
// [R21] flags 4-6 cleared when command starts
// [R22] execute on data strobe trailing edge
// [R23] host may load command and arguments anyway
// [R24] host issues dummy execute command first
// [R25] busy restricts host register access
// [R26] busy without execute: only status read
// [R27] busy with execute: command write aborts
// [R28] busy and flags reset to zero
`timescale 1ns/1ps
module muxed_host_command_port
	import host_port_pkg::*;
(
	// clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      arst_n_i,
	// host multiplexed bus
	input  wire logic [host_port_pkg::ADDR_W-1:0] bus_i,
	output logic      [host_port_pkg::ADDR_W-1:0] bus_o,
	output logic                           bus_oe_n_o,
	input  wire logic                      address_latch_strobe_i,
	input  wire logic                      data_phase_strobe_n_i,
	input  wire logic                      read_not_write_i,
	input  wire logic                      chip_select_n_i,
	// display engine side
	input  wire logic                      vsync_i,
	input  wire logic                      cmd_done_i,
	input  wire logic                      row_end_main_i,
	input  wire logic                      row_end_aux_i,
	input  wire logic                      ptr_increment_i,
	input  wire logic                      arg_wr_i,
	input  wire logic [2:0]                arg_idx_i,
	input  wire logic [7:0]                arg_data_i,
	output logic                           cmd_start_o,
	output logic [7:0]                     command_o,
	output logic [55:0]                    args_o
);
	import host_port_pkg::*;

	// every check below lives in the single clock domain of this port
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	// pin synchronisers
	logic [7:0] bus_s1_reg, bus_s2_reg;
	logic       as_s1_reg, as_s2_reg, as_d_reg;
	logic       ds_s1_reg, ds_s2_reg, ds_d_reg;
	logic       rw_s1_reg, rw_s2_reg;
	logic       cs_s1_reg, cs_s2_reg;
	logic       vs_s1_reg, vs_s2_reg;
	// state
	logic [8:0] addr_reg;
	logic [7:0] command_word_reg;
	logic [7:0] arg_reg [1:7];
	logic       busy_reg, alarm_reg, main_end_reg, aux_end_reg;
	logic       vmask_reg, start_reg;
	logic [7:0] rd_data_reg;
	logic       drive_reg;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bus_s1_reg <= 8'h00;
			bus_s2_reg <= 8'h00;
			{as_s1_reg, as_s2_reg, as_d_reg} <= 3'h0;
			{ds_s1_reg, ds_s2_reg, ds_d_reg} <= 3'h7;
			{rw_s1_reg, rw_s2_reg} <= 2'h3;
			{cs_s1_reg, cs_s2_reg} <= 2'h3;
			{vs_s1_reg, vs_s2_reg} <= 2'h0;
		end else begin
			bus_s1_reg <= bus_i;
			bus_s2_reg <= bus_s1_reg;
			as_s1_reg  <= address_latch_strobe_i;
			as_s2_reg  <= as_s1_reg;
			as_d_reg   <= as_s2_reg;
			ds_s1_reg  <= data_phase_strobe_n_i;
			ds_s2_reg  <= ds_s1_reg;
			ds_d_reg   <= ds_s2_reg;
			rw_s1_reg  <= read_not_write_i;
			rw_s2_reg  <= rw_s1_reg;
			cs_s1_reg  <= chip_select_n_i;
			cs_s2_reg  <= cs_s1_reg;
			vs_s1_reg  <= vsync_i;
			vs_s2_reg  <= vs_s1_reg;
		end
	end

	// decode
	wire       as_fall   = as_d_reg & ~as_s2_reg;
	wire       ds_active = ~ds_s2_reg;
	wire       ds_rise   = ~ds_d_reg & ds_s2_reg;
	wire [2:0] idx       = addr_reg[ADR_IDX_LSB +: 3];             // [R2]
	wire       exec_req  = addr_reg[ADR_EXEC_BIT];
	wire [3:0] nibble    = addr_reg[ADR_NIB_LSB +: 4];
	wire       sel_n     = addr_reg[8];
	wire       selected  = (nibble == SELECT_NIBBLE) && !sel_n;    // [R3]
	wire       access    = selected && !as_s2_reg && ds_active;    // [R5]
	wire       is_cmd    = (idx == IDX_CMD_STAT);
	// busy gating of the data phase
	wire       allow_arg = !busy_reg;                              // [R25]
	wire       allow_cmd = !busy_reg || exec_req;                  // [R26] [R27]
	wire       wr_now    = access && !rw_s2_reg;                   // [R4]
	wire       cmd_wr    = wr_now && is_cmd && allow_cmd;          // [R6]
	wire       arg_wr    = wr_now && !is_cmd && allow_arg;         // [R7]
	wire       launch    = ds_rise && selected && exec_req;        // [R22]
	wire [7:0] status_word;
	wire [7:0] cmd_next  = cmd_wr ? bus_s2_reg : command_word_reg;
	wire       vsync_bit = !vmask_reg && vs_s2_reg;                // [R18] [R19]
	// move and stop fields of the held command, passed on to the engine
	wire [1:0] move_code = command_word_reg[3:2];                  // [R12]
	wire [1:0] stop_code = command_word_reg[1:0];                  // [R13]

	assign status_word = {busy_reg, alarm_reg, main_end_reg,       // [R14]
		aux_end_reg, arg_reg[IDX_DATA_ONE][7],                     // [R17]
		vsync_bit, 2'b00};                                         // [R20]

	// address phase latch
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			addr_reg <= 9'h100;
		else if (as_fall)
			addr_reg <= {cs_s2_reg, bus_s2_reg};                   // [R1]
	end

	// command and argument registers
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			command_word_reg <= REG_RESET;
			for (int i = 1; i < 8; i++)
				arg_reg[i] <= REG_RESET;
		end else begin
			command_word_reg <= cmd_next;                          // [R9]
			if (arg_wr)
				arg_reg[idx] <= bus_s2_reg;                        // [R23]
			else if (arg_wr_i && arg_idx_i != IDX_CMD_STAT)
				arg_reg[arg_idx_i] <= arg_data_i;                  // [R8] [R10]
		end
	end

	// busy, status flags and vertical sync mask
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_reg     <= 1'b0;                                  // [R28]
			alarm_reg    <= 1'b0;
			main_end_reg <= 1'b0;
			aux_end_reg  <= 1'b0;
			vmask_reg    <= MASK_RESET;
			start_reg    <= 1'b0;
		end else begin
			start_reg <= launch;
			if (launch) begin
				busy_reg     <= 1'b1;                              // [R14]
				alarm_reg    <= 1'b0;                              // [R21]
				main_end_reg <= 1'b0;
				aux_end_reg  <= 1'b0;
				if (cmd_next == VSYNC_SET_CMD)
					vmask_reg <= 1'b1;
				else if (cmd_next == VSYNC_CLR_CMD)
					vmask_reg <= 1'b0;
			end else begin
				if (cmd_done_i)
					busy_reg <= 1'b0;
				if (row_end_main_i)
					main_end_reg <= 1'b1;                          // [R15]
				if (row_end_aux_i)
					aux_end_reg <= 1'b1;
				if ((row_end_main_i || row_end_aux_i) && ptr_increment_i)
					alarm_reg <= 1'b1;                             // [R16]
			end
		end
	end

	// read path: data outputs from flip-flops
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_data_reg <= 8'h00;
			drive_reg   <= 1'b0;
		end else begin
			drive_reg <= access && rw_s2_reg;                      // [R4]
			if (is_cmd)
				rd_data_reg <= status_word;
			else if (allow_arg)
				rd_data_reg <= arg_reg[idx];
			else
				rd_data_reg <= 8'h00;                              // [R26]
		end
	end

	assign bus_o       = rd_data_reg;
	assign bus_oe_n_o  = !drive_reg;
	assign cmd_start_o = start_reg;
	assign command_o   = command_word_reg;
	assign args_o      = {arg_reg[7], arg_reg[6], arg_reg[5], arg_reg[4],
		arg_reg[3], arg_reg[2], arg_reg[1]};
	// field meanings for the engine: [R11] [R12] [R13] [R24]

	// launch and busy

	a_busy_on_launch: assert property ( // [R14]
		launch |=> busy_reg && cmd_start_o)
		else $error("busy not set");

	a_busy_clears: assert property ( // [R14]
		cmd_done_i && !launch |=> !busy_reg)
		else $error("busy not cleared");

	a_flags_cleared: assert property ( // [R21]
		launch |=> !alarm_reg && !main_end_reg && !aux_end_reg)
		else $error("flags not cleared");

	a_start_pulse: assert property ( // [R22]
		cmd_start_o |=> !cmd_start_o)
		else $error("start longer than one cycle");

	a_launch_needs_sel: assert property ( // [R22]
		cmd_start_o |-> $past(selected && exec_req))
		else $error("launch without select");

	// selection and bus ownership

	a_float_unsel: assert property ( // [R4]
		!selected |=> bus_oe_n_o)
		else $error("bus driven unselected");

	a_no_write_unsel: assert property ( // [R4]
		!selected |=> $stable(command_word_reg))
		else $error("write unselected");

	a_read_drives: assert property ( // [R5]
		access && rw_s2_reg |=> !bus_oe_n_o)
		else $error("read not driven");

	a_addr_latch: assert property ( // [R1]
		as_fall |=> addr_reg == $past({cs_s2_reg, bus_s2_reg}))
		else $error("address not latched");

	// register writes and reads

	a_cmd_write: assert property ( // [R6]
		cmd_wr |=> command_o == $past(bus_s2_reg))
		else $error("command not written");

	a_status_read: assert property ( // [R6]
		is_cmd |=> bus_o == $past(status_word))
		else $error("status not read");

	a_arg_write: assert property ( // [R7]
		arg_wr |=> arg_reg[$past(idx)] == $past(bus_s2_reg))
		else $error("argument not written");

	a_busy_lock: assert property ( // [R26]
		busy_reg && !exec_req |=> $stable(command_word_reg))
		else $error("command written while busy");

	a_arg_lock: assert property ( // [R26]
		busy_reg && wr_now && !is_cmd && !arg_wr_i |=> $stable(args_o))
		else $error("argument written while busy");

	a_busy_reads_zero: assert property ( // [R26]
		busy_reg && !is_cmd |=> bus_o == 8'h00)
		else $error("argument read while busy");

	// status bits

	a_low_bits_zero: assert property ( // [R20]
		status_word[1:0] == 2'b00)
		else $error("low status bits set");

	a_status_msb: assert property ( // [R17]
		status_word[ST_DATA_MSB] == arg_reg[IDX_DATA_ONE][7])
		else $error("data msb mismatch");

	a_main_end_set: assert property ( // [R15]
		row_end_main_i && !launch |=> main_end_reg)
		else $error("main row end lost");

	a_aux_end_set: assert property ( // [R15]
		row_end_aux_i && !launch |=> aux_end_reg)
		else $error("aux row end lost");

	a_alarm_set: assert property ( // [R16]
		(row_end_main_i || row_end_aux_i) && ptr_increment_i && !launch
		|=> alarm_reg)
		else $error("alarm not set");

	a_alarm_cause: assert property ( // [R16]
		$rose(alarm_reg) |-> $past(ptr_increment_i))
		else $error("alarm without increment");

	// vertical sync mask

	a_mask_forces: assert property ( // [R19]
		vmask_reg |-> !status_word[ST_VSYNC])
		else $error("vsync leaks");

	a_mask_set_cmd: assert property ( // [R19]
		launch && cmd_next == VSYNC_SET_CMD |=> vmask_reg)
		else $error("mask not set");

	a_mask_clr_cmd: assert property ( // [R18]
		launch && cmd_next == VSYNC_CLR_CMD |=> !vmask_reg)
		else $error("mask not cleared");

	a_mask_holds: assert property ( // [R19]
		!launch |=> $stable(vmask_reg))
		else $error("mask moved without command");

	// main scenarios

	c_launch: cover property (launch);

	c_abort: cover property (busy_reg && launch);

	c_read: cover property (!bus_oe_n_o);

	c_alarm: cover property ($rose(alarm_reg));

	c_move_cmd: cover property (launch && move_code == SRC_MAIN_AUX
		&& stop_code == STOP_NEVER);
endmodule : muxed_host_command_port

// File: host_port_pkg.sv
// constants for the multiplexed host command port
package host_port_pkg;
	localparam int          ADDR_W        = 8;
	localparam logic [2:0]  IDX_CMD_STAT  = 3'h0;
	localparam logic [2:0]  IDX_DATA_ONE  = 3'h1;
	localparam logic [2:0]  IDX_DATA_TWO  = 3'h2;
	localparam logic [2:0]  IDX_DATA_THR  = 3'h3;
	localparam logic [2:0]  IDX_AUX_A     = 3'h4;
	localparam logic [2:0]  IDX_AUX_B     = 3'h5;
	localparam logic [2:0]  IDX_MAIN_A    = 3'h6;
	localparam logic [2:0]  IDX_MAIN_B    = 3'h7;
	localparam int          ADR_IDX_LSB   = 0;
	localparam int          ADR_EXEC_BIT  = 3;
	localparam int          ADR_NIB_LSB   = 4;
	localparam logic [3:0]  SELECT_NIBBLE = 4'h2;
	localparam int          ST_BUSY       = 7;
	localparam int          ST_ALARM      = 6;
	localparam int          ST_MAIN_END   = 5;
	localparam int          ST_AUX_END    = 4;
	localparam int          ST_DATA_MSB   = 3;
	localparam int          ST_VSYNC      = 2;
	localparam int          CMD_TYPE_LSB  = 4;
	localparam int          PRM_DIR       = 3;
	localparam int          PRM_INC       = 2;
	localparam int          PRM_PTR       = 1;
	localparam logic [1:0]  SRC_MAIN_AUX  = 2'h1;
	localparam logic [1:0]  SRC_AUX_MAIN  = 2'h2;
	localparam logic [1:0]  STOP_AT_END   = 2'h1;
	localparam logic [1:0]  STOP_NEVER    = 2'h2;
	localparam logic [7:0]  VSYNC_SET_CMD = 8'h99;
	localparam logic [7:0]  VSYNC_CLR_CMD = 8'h95;
	localparam logic [5:0]  ROW_LAST_X    = 6'h27;
	localparam logic [7:0]  REG_RESET     = 8'h00;
	localparam logic        MASK_RESET    = 1'b1;
endpackage : host_port_pkg

// File: host_bus_model.sv
// host processor model on the multiplexed address/data bus
`timescale 1ns/1ps
module host_bus_model (
	// clock
	input  wire logic       clk_i,
	// device pins
	input  wire logic [7:0] bus_o,
	input  wire logic       bus_oe_n_o,
	output logic      [7:0] bus_i,
	output logic            as_o,
	output logic            ds_n_o,
	output logic            rw_o,
	output logic            cs_n_o
);
	logic [7:0] drv;
	// the device owns the wire while its enable is low
	assign bus_i = bus_oe_n_o ? drv : bus_o;
	initial begin
		drv = 8'h00;
		as_o = 1'b0;
		ds_n_o = 1'b1;
		rw_o = 1'b1;
		cs_n_o = 1'b1;
	end
	// each strobe level is held past the device's sync delay
	task automatic cycle(input logic [7:0] adr, input logic csn,
		input logic rd, input logic [7:0] wd,
		output logic [7:0] rdat, output logic oe_n);
		as_o <= 1'b1;
		drv <= adr;
		cs_n_o <= csn;
		repeat (4) @(posedge clk_i);
		as_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		rw_o <= rd;
		ds_n_o <= 1'b0;
		drv <= rd ? ~adr : wd;
		repeat (6) @(posedge clk_i);
		rdat = bus_i;
		oe_n = bus_oe_n_o;
		ds_n_o <= 1'b1;
		rw_o <= 1'b1;
		drv <= ~drv;
		repeat (6) @(posedge clk_i);
	endtask : cycle
endmodule : host_bus_model

// File: muxed_host_command_port_tb.sv
// self-checking bench for the multiplexed host command port
`timescale 1ns/1ps
module muxed_host_command_port_tb;
	import host_port_pkg::*;
	logic        clk_i, arst_n_i, vsync_i, cmd_done_i, row_end_i, inc_i;
	logic        aux_i, eng_wr;
	logic [2:0]  eng_idx;
	logic [7:0]  eng_dat;
	logic [7:0]  bus_i, bus_o, rd, cmd_o, lfsr_v;
	logic        oe_n, as, ds_n, rw, cs_n, oe_seen, start;
	logic [55:0] args;
	int          err_count, compares, starts, nst, cyc;
	int          regs[8];
	bit          busy, mask, alarm, mend, aend;
	logic [15:0] lfsr;
	muxed_host_command_port i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.bus_i(bus_i), .bus_o(bus_o), .bus_oe_n_o(oe_n),
		.address_latch_strobe_i(as), .data_phase_strobe_n_i(ds_n),
		.read_not_write_i(rw), .chip_select_n_i(cs_n), .vsync_i(vsync_i),
		.cmd_done_i(cmd_done_i), .row_end_main_i(row_end_i),
		.row_end_aux_i(aux_i), .ptr_increment_i(inc_i), .arg_wr_i(eng_wr),
		.arg_idx_i(eng_idx), .arg_data_i(eng_dat), .cmd_start_o(start),
		.command_o(cmd_o), .args_o(args));
	host_bus_model i_host (.clk_i(clk_i), .bus_o(bus_o), .bus_oe_n_o(oe_n),
		.bus_i(bus_i), .as_o(as), .ds_n_o(ds_n), .rw_o(rw), .cs_n_o(cs_n));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (start === 1'b1)
			starts++;
		if (cyc == 8000) begin
			err_count++;
			give_verdict();
		end
	end
	function automatic logic [15:0] nxt(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nxt
	function automatic logic [7:0] exp_st();
		return {busy, alarm, mend, aend, regs[1][7], vsync_i & ~mask, 2'h0};
	endfunction : exp_st
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		i_host.cycle(a, 1'b0, 1'b0, d, rd, oe_seen);
	endtask : wr
	task automatic rchk(logic [7:0] a, string nm, logic [7:0] e);
		i_host.cycle(a, 1'b0, 1'b1, 8'h00, rd, oe_seen);
		chk(nm, e, rd);
	endtask : rchk
	task automatic ex(logic [7:0] c);
		wr(8'h28, c);
		busy = 1;
		alarm = 0;
		mend = 0;
		aend = 0;
		nst++;
		chk("starts", 8'(nst), 8'(starts));
		chk("command", c, cmd_o);
	endtask : ex
	task automatic done();
		cmd_done_i <= 1'b1;
		@(posedge clk_i);
		cmd_done_i <= 1'b0;
		busy = 0;
		repeat (4) @(posedge clk_i);
	endtask : done
	task automatic give_verdict();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	initial begin
		arst_n_i = 1'b0;
		vsync_i = 1'b0;
		cmd_done_i = 1'b0;
		row_end_i = 1'b0;
		inc_i = 1'b0;
		aux_i = 1'b0;
		eng_wr = 1'b0;
		eng_idx = 3'h0;
		eng_dat = 8'h00;
		lfsr = 16'h5eea;
		mask = 1;
		repeat (16) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("oe_n", 8'h01, {7'h0, oe_n});
		rchk(8'h20, "status", exp_st());
		ex(8'h00);
		rchk(8'h20, "status", exp_st());
		done();
		for (int i = 1; i < 8; i++) begin
			lfsr = nxt(lfsr);
			regs[i] = lfsr[7:0];
			wr(8'h20 | 8'(i), lfsr[7:0]);
		end
		for (int i = 1; i < 8; i++) begin
			rchk(8'h20 | 8'(i), "arg_rd", 8'(regs[i]));
			chk("oe_n", 8'h00, {7'h0, oe_seen});
			chk("args_o", 8'(regs[i]), args[8*i-8 +: 8]);
		end
		wr(8'h31, 8'haa);
		i_host.cycle(8'h21, 1'b1, 1'b0, 8'h55, rd, oe_seen);
		i_host.cycle(8'h21, 1'b1, 1'b1, 8'h00, rd, oe_seen);
		chk("oe_n", 8'h01, {7'h0, oe_seen});
		for (int v = 0; v < 2; v++) begin
			rchk(8'h21, "arg_rd", 8'(regs[1]));
			regs[1] = {v[0], 7'h35};
			wr(8'h21, 8'(regs[1]));
			rchk(8'h20, "status", exp_st());
		end
		wr(8'h20, 8'h91);
		chk("command", 8'h91, cmd_o);
		chk("starts", 8'(nst), 8'(starts));
		vsync_i <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			ex(k == 0 ? VSYNC_CLR_CMD : VSYNC_SET_CMD);
			mask = k;
			done();
			rchk(8'h20, "status", exp_st());
		end
		ex(8'h31);
		wr(8'h21, 8'h3c);
		rchk(8'h21, "busy_rd", 8'h00);
		row_end_i <= 1'b1;
		aux_i <= 1'b1;
		inc_i <= 1'b1;
		@(posedge clk_i);
		row_end_i <= 1'b0;
		aux_i <= 1'b0;
		inc_i <= 1'b0;
		alarm = 1;
		mend = 1;
		aend = 1;
		repeat (4) @(posedge clk_i);
		rchk(8'h20, "status", exp_st());
		ex(8'hd6);
		wr(8'h29, 8'h44);
		rchk(8'h20, "status", exp_st());
		done();
		rchk(8'h21, "arg_rd", 8'(regs[1]));
		lfsr = nxt(lfsr);
		regs[2] = lfsr[7:0];
		eng_idx <= 3'h2;
		eng_dat <= lfsr[7:0];
		eng_wr <= 1'b1;
		@(posedge clk_i);
		eng_wr <= 1'b0;
		rchk(8'h22, "eng_rd", 8'(regs[2]));
		give_verdict();
	end
endmodule : muxed_host_command_port_tb
